// ===== logic/udt_pkg.sv
// Operation
// - Locked, timer at limit with check enabled: insert one filler, go tardy-fill.
// - Locked, cell directly follows previous: accept, stay locked, arm timer.
// - Locked, cell one beyond expected: filler, accept, order error, one-gap-probe.
// - Locked, other disorder: accept without filler, order error, disorder state.
// - Bad-number, follows last good: discard, stray flag, locked, arm timer.
// - Bad-number, valid and two beyond last good: accept, locked, arm timer.
// - Bad-number or disorder, other valid cell: discard, go unlocked.
// - Disorder, follows last received: fill missing (max 7), accept, missing flag, lock.
// - Disorder, valid and two beyond last in-sequence: accept, locked, arm timer.
// - Late timer is armed on entry to locked and rearmed by each in-sequence cell there, so late fill only when locked.
// - Late check runs only if enabled; timeout when counter reaches programmed value.
// - Cell number is the 3 low sequence bits plus validity, for every cell.
package udt_pkg;

  // Register byte offsets
  localparam logic [7:0] UDT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] UDT_LIMIT_OFS  = 8'h04;
  localparam logic [7:0] UDT_STATUS_OFS = 8'h08;
  localparam logic [7:0] UDT_MASK_OFS   = 8'h0c;
  localparam logic [7:0] UDT_STATE_OFS  = 8'h10;

  // Field positions and reset values
  localparam int          UDT_CTRL_LATE_EN_BIT = 0;
  localparam int          UDT_EVT_W            = 5;
  localparam int          UDT_EVT_ORDER        = 0;
  localparam int          UDT_EVT_MISSING      = 1;
  localparam int          UDT_EVT_STRAY        = 2;
  localparam int          UDT_EVT_LATE         = 3;
  localparam int          UDT_EVT_TIMEOUT      = 4;
  localparam int          UDT_TMR_W            = 16;
  localparam logic [15:0] UDT_LIMIT_RST        = 16'hffff;
  localparam int          UDT_ST_GOOD_POS      = 4;
  localparam int          UDT_ST_LAST_POS      = 8;
  localparam int          UDT_ST_FILL_POS      = 12;

  typedef enum logic [2:0] {
    UDT_START, UDT_UNLOCKED, UDT_LOCKED, UDT_BAD_NUMBER,
    UDT_DISORDER, UDT_GAP_PROBE, UDT_TARDY_FILL
  } udt_state_t;

  // Cell from the header checker
  typedef struct packed {
    logic       valid;
    logic [2:0] sn;
    logic       sn_ok;
  } udt_cell_in_t;

  // Write toward the reassembly buffer writer
  typedef struct packed {
    logic       wr;
    logic       filler;
    logic [2:0] sn;
  } udt_cell_out_t;

endpackage

// ===== logic/udt_cell_sequence_tracker.sv
`timescale 1ns/10ps
module udt_cell_sequence_tracker (
  // Clock, reset, enable
  input  wire  logic                  pclk,
  input  wire  logic                  presetn,
  input  wire  logic                  ce,
  // APB slave
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [7:0]            paddr,
  input  wire  logic [31:0]           pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Cell stream
  input  wire  udt_pkg::udt_cell_in_t cell_in,
  output logic                        cell_ready,
  output udt_pkg::udt_cell_out_t      cell_out,
  // Interrupt
  output logic                        irq
);
  import udt_pkg::*;

  udt_state_t                 state_reg, state_next;
  logic [2:0]                 good_reg, good_next;
  logic [2:0]                 last_reg, last_next;
  logic [2:0]                 fill_reg, fill_next;
  logic [2:0]                 fsn_reg, fsn_next;
  logic                       pacc_reg, pacc_next;
  logic [2:0]                 psn_reg, psn_next;
  logic                       armed_reg, armed_next;
  logic [UDT_TMR_W-1:0]       tmr_reg;
  logic                       late_en_reg;
  logic [UDT_TMR_W-1:0]       limit_reg;
  logic [UDT_EVT_W-1:0]       status_reg, mask_reg, evt_set;
  logic                       take, timeout, busy;
  logic                       acc, arm;
  logic [2:0]                 nfill;
  logic                       apb_acc, apb_wr, apb_hit;
  logic [31:0]                rd_data;

  function automatic logic [2:0] sn_add(input logic [2:0] a, input logic [2:0] b);
    sn_add = a + b;
  endfunction

  assign busy    = (fill_reg != 3'h0) || pacc_reg;
  assign take    = cell_in.valid && cell_ready;
  assign timeout = (state_reg == UDT_LOCKED) && armed_reg && late_en_reg
                   && (tmr_reg == limit_reg) && !busy && !take;

  // Sequence decision on each taken cell
  always_comb begin
    state_next = state_reg;
    good_next  = good_reg;
    last_next  = last_reg;
    acc        = 1'b0;
    arm        = 1'b0;
    nfill      = 3'h0;
    fsn_next   = sn_add(good_reg, 3'h1);
    evt_set    = '0;
    if (take) begin
      last_next = cell_in.sn;
      case (state_reg)
        UDT_START: begin
          if (cell_in.sn_ok)
            state_next = UDT_UNLOCKED;
        end
        UDT_UNLOCKED: begin
          if (!cell_in.sn_ok) begin
            state_next = UDT_START;
          end else if (cell_in.sn == sn_add(last_reg, 3'h1)) begin
            acc        = 1'b1;
            arm        = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end
        end
        UDT_LOCKED: begin
          acc = 1'b1;
          if (!cell_in.sn_ok) begin
            state_next = UDT_BAD_NUMBER;
            last_next  = last_reg;
          end else if (cell_in.sn == sn_add(good_reg, 3'h1)) begin
            arm       = 1'b1;
            good_next = cell_in.sn;
          end else if (cell_in.sn == sn_add(good_reg, 3'h2)) begin
            nfill      = 3'h1;
            evt_set[UDT_EVT_ORDER] = 1'b1;
            state_next = UDT_GAP_PROBE;
          end else begin
            evt_set[UDT_EVT_ORDER] = 1'b1;
            state_next = UDT_DISORDER;
          end
        end
        UDT_BAD_NUMBER: begin
          if (!cell_in.sn_ok) begin
            state_next = UDT_START;
          end else if (cell_in.sn == sn_add(good_reg, 3'h1)) begin
            evt_set[UDT_EVT_STRAY] = 1'b1;
            arm        = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else if (cell_in.sn == sn_add(good_reg, 3'h2)) begin
            acc        = 1'b1;
            arm        = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else begin
            state_next = UDT_UNLOCKED;
          end
        end
        UDT_DISORDER: begin
          if (!cell_in.sn_ok) begin
            state_next = UDT_START;
          end else if (cell_in.sn == sn_add(last_reg, 3'h1)) begin
            nfill      = last_reg - good_reg - 3'h1;
            acc        = 1'b1;
            arm        = 1'b1;
            evt_set[UDT_EVT_MISSING] = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else if (cell_in.sn == sn_add(good_reg, 3'h2)) begin
            acc        = 1'b1;
            arm        = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else begin
            state_next = UDT_UNLOCKED;
          end
        end
        UDT_GAP_PROBE: begin
          if (!cell_in.sn_ok) begin
            state_next = UDT_START;
          end else if (cell_in.sn == sn_add(last_reg, 3'h1)) begin
            acc        = 1'b1;
            arm        = 1'b1;
            evt_set[UDT_EVT_MISSING] = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else if (cell_in.sn == sn_add(good_reg, 3'h1)) begin
            arm        = 1'b1;
            evt_set[UDT_EVT_STRAY] = 1'b1;
            good_next  = last_reg;
            last_next  = last_reg;
            state_next = UDT_LOCKED;
          end else if (cell_in.sn == sn_add(good_reg, 3'h2)) begin
            arm        = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else begin
            state_next = UDT_UNLOCKED;
          end
        end
        UDT_TARDY_FILL: begin
          if (!cell_in.sn_ok) begin
            state_next = UDT_START;
          end else if (cell_in.sn == sn_add(good_reg, 3'h2)) begin
            acc        = 1'b1;
            arm        = 1'b1;
            evt_set[UDT_EVT_MISSING] = 1'b1;
            evt_set[UDT_EVT_ORDER]   = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else if (cell_in.sn == sn_add(good_reg, 3'h1)) begin
            arm        = 1'b1;
            evt_set[UDT_EVT_LATE] = 1'b1;
            good_next  = cell_in.sn;
            state_next = UDT_LOCKED;
          end else begin
            evt_set[UDT_EVT_ORDER] = 1'b1;
            state_next = UDT_UNLOCKED;
          end
        end
        default: state_next = UDT_START;
      endcase
    end else if (timeout) begin
      nfill      = 3'h1;
      good_next  = sn_add(good_reg, 3'h0);
      evt_set[UDT_EVT_TIMEOUT] = 1'b1;
      state_next = UDT_TARDY_FILL;
    end
  end

  // Fillers are issued first, the held cell follows
  always_comb begin
    fill_next = fill_reg;
    pacc_next = pacc_reg;
    psn_next  = psn_reg;
    if (fill_reg != 3'h0)
      fill_next = fill_reg - 3'h1;
    else if (pacc_reg)
      pacc_next = 1'b0;
    if (take || timeout) begin
      fill_next = nfill;
      pacc_next = acc;
      psn_next  = cell_in.sn;
    end
  end

  // Timer arms on entry to locked and on each in-sequence cell there, stops elsewhere
  assign armed_next = (state_next == UDT_LOCKED) && (arm || (armed_reg && !take));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= UDT_START;
      good_reg  <= 3'h0;
      last_reg  <= 3'h0;
      armed_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      good_reg  <= good_next;
      last_reg  <= last_next;
      armed_reg <= armed_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_reg <= 3'h0;
      fsn_reg  <= 3'h0;
      pacc_reg <= 1'b0;
      psn_reg  <= 3'h0;
      cell_out <= '0;
    end else if (ce) begin
      fill_reg <= fill_next;
      pacc_reg <= pacc_next;
      psn_reg  <= psn_next;
      if (take || timeout)
        fsn_reg <= fsn_next;
      else if (fill_reg != 3'h0)
        fsn_reg <= sn_add(fsn_reg, 3'h1);
      cell_out.wr     <= (fill_reg != 3'h0) || pacc_reg;
      cell_out.filler <= (fill_reg != 3'h0);
      cell_out.sn     <= (fill_reg != 3'h0) ? fsn_reg : psn_reg;
    end
  end

  // Cell intake stalls while fillers or a held cell are pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cell_ready <= 1'b0;
    else if (ce)
      cell_ready <= (fill_next == 3'h0) && !pacc_next && !(take || timeout);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tmr_reg <= '0;
    else if (ce) begin
      if (!armed_next || arm)
        tmr_reg <= '0;
      else if (tmr_reg != limit_reg)
        tmr_reg <= tmr_reg + 1'b1;
    end
  end

  // APB slave, one wait state
  assign apb_acc = psel && penable && !pready;
  assign apb_wr  = apb_acc && pwrite;
  assign apb_hit = (paddr == UDT_CTRL_OFS) || (paddr == UDT_LIMIT_OFS)
                   || (paddr == UDT_STATUS_OFS) || (paddr == UDT_MASK_OFS)
                   || (paddr == UDT_STATE_OFS);

  always_comb begin
    rd_data = 32'h0;
    case (paddr)
      UDT_CTRL_OFS:   rd_data[UDT_CTRL_LATE_EN_BIT] = late_en_reg;
      UDT_LIMIT_OFS:  rd_data[UDT_TMR_W-1:0] = limit_reg;
      UDT_STATUS_OFS: rd_data[UDT_EVT_W-1:0] = status_reg;
      UDT_MASK_OFS:   rd_data[UDT_EVT_W-1:0] = mask_reg;
      UDT_STATE_OFS: begin
        rd_data[2:0]                         = state_reg;
        rd_data[UDT_ST_GOOD_POS +: 3]        = good_reg;
        rd_data[UDT_ST_LAST_POS +: 3]        = last_reg;
        rd_data[UDT_ST_FILL_POS +: 3]        = fill_reg;
      end
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      pready  <= apb_acc;
      pslverr <= apb_acc && !apb_hit;
      prdata  <= (apb_acc && !pwrite) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      late_en_reg <= 1'b0;
      limit_reg   <= UDT_LIMIT_RST;
      mask_reg    <= '0;
    end else if (ce && apb_wr) begin
      if (paddr == UDT_CTRL_OFS)
        late_en_reg <= pwdata[UDT_CTRL_LATE_EN_BIT];
      if (paddr == UDT_LIMIT_OFS)
        limit_reg <= pwdata[UDT_TMR_W-1:0];
      if (paddr == UDT_MASK_OFS)
        mask_reg <= pwdata[UDT_EVT_W-1:0];
    end
  end

  // Sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
      irq        <= 1'b0;
    end else if (ce) begin
      status_reg <= (status_reg & ~((apb_wr && paddr == UDT_STATUS_OFS) ?
                    pwdata[UDT_EVT_W-1:0] : '0)) | evt_set;
      irq        <= |(status_reg & mask_reg);
    end
  end

endmodule // udt_cell_sequence_tracker

// ===== bench/udt_seq_checker.sv
`timescale 1ns/10ps
module udt_seq_checker (
  // Clock, reset, enable
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   ce,
  // Register bus
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Cell stream and interrupt
  input wire udt_pkg::udt_cell_in_t  cell_in,
  input wire logic                   cell_ready,
  input wire udt_pkg::udt_cell_out_t cell_out,
  input wire logic                   irq
);
  import udt_pkg::*;
  logic [2:0] take_sn_reg;
  logic [3:0] run_reg;

  // Number of the cell taken last, and length of the current write burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) take_sn_reg <= 3'h0;
    else if (ce && cell_in.valid && cell_ready) take_sn_reg <= cell_in.sn;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_reg <= 4'h0;
    else if (!ce) run_reg <= run_reg;
    else if (!cell_out.wr) run_reg <= 4'h0;
    else if (run_reg != 4'hf) run_reg <= run_reg + 4'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TAKE_DROPS_READY: assert property (cell_in.valid && cell_ready |=> !cell_ready)
    else $error("cell ready stayed high after a take");
  // A take with no write two cycles on was a discard: intake must be open again
  AST_DISCARD_READY: assert property (
    cell_in.valid && cell_ready ##2 !cell_out.wr |-> cell_ready)
    else $error("ready late after a discarded cell");
  // The last write of a burst may overlap reopened intake, but no write follows it
  AST_WR_WHILE_BUSY: assert property (cell_out.wr && cell_ready |=> !cell_out.wr)
    else $error("write burst went on after intake reopened");
  AST_ACCEPT_SN: assert property (
    cell_out.wr && !cell_out.filler |-> cell_out.sn == take_sn_reg)
    else $error("accepted cell written with a wrong number");
  AST_FILL_UPWARD: assert property (
    cell_out.wr && cell_out.filler && $past(cell_out.wr && cell_out.filler)
    |-> cell_out.sn == $past(cell_out.sn) + 3'h1)
    else $error("filler numbers not ascending");
  AST_FILL_MAX: assert property (run_reg <= 4'h8)
    else $error("more than seven fillers in a burst");
  AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("bus ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
endmodule // udt_seq_checker

// ===== bench/udt_far_end.sv
`timescale 1ns/10ps
module udt_far_end (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Bench requests
  input  wire logic                   go,
  input  wire logic [2:0]             go_sn,
  input  wire logic                   go_ok,
  // Tracker side
  input  wire logic                   cell_ready,
  input  wire udt_pkg::udt_cell_out_t cell_out,
  output udt_pkg::udt_cell_in_t       cell_in
);
  import udt_pkg::*;
  logic [3:0] got[$];

  // Header checker offers one number until taken; buffer writer logs every write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_in <= '0;
      got.delete();
    end else begin
      if (cell_out.wr) got.push_back({cell_out.filler, cell_out.sn});
      if (cell_in.valid && cell_ready) begin
        cell_in.valid <= 1'b0;
        // Released number shows no stale value
        cell_in.sn    <= ~cell_in.sn;
        cell_in.sn_ok <= ~cell_in.sn_ok;
      end else if (go && !cell_in.valid) cell_in <= '{1'b1, go_sn, go_ok};
    end
  end
endmodule // udt_far_end

// ===== bench/tb_udt_cell_sequence_tracker.sv
`timescale 1ns/10ps
module tb_udt_cell_sequence_tracker;
  import udt_pkg::*;
  logic          pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, perr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, q;
  udt_cell_in_t  cell_in;
  logic          cell_ready;
  udt_cell_out_t cell_out;
  logic          go, go_ok;
  logic [2:0]    go_sn, b;
  logic [7:0]    rnd;
  logic [3:0]    expq[$];
  int            error_cnt, tests_run;

  udt_cell_sequence_tracker dut (.*);
  udt_far_end far (.*);
  always #5 pclk = ~pclk;

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends on pready; if pready never comes, only the watchdog ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic irqc(input logic e);
    repeat (2) @(posedge pclk);
    chk(irq, e);
  endtask
  task automatic want(input logic f, input logic [2:0] o);
    expq.push_back({f, b + o});
  endtask
  // Writes seen since the last call against the expected list, then the state
  task automatic cmp(input logic [2:0] nxt);
    // Let the far end log a write that stands at the edge the caller woke on
    @(posedge pclk);
    chk(far.got.size(), expq.size());
    foreach (expq[i]) if (i < far.got.size()) chk(far.got[i], expq[i]);
    expq.delete();
    far.got.delete();
    apb(1'b0, UDT_STATE_OFS, 32'h0);
    chk(q[2:0], nxt);
  endtask
  task automatic snd(input logic [2:0] o, input logic ok, input logic [2:0] nxt);
    @(posedge pclk);
    go    <= 1'b1;
    go_sn <= b + o;
    go_ok <= ok;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
    end while (!(cell_ready === 1'b1 && cell_in.valid === 1'b0));
    cmp(nxt);
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, go, go_ok} = '0;
    {paddr, pwdata, go_sn} = '0;
    ce = 1'b1;
    rnd = 8'h5b;
    error_cnt = 0;
    tests_run = 0;
    for (int p = 0; p < 2; p++) begin
      rnd = lfsr(rnd);
      b = rnd[2:0];
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(UDT_LIMIT_OFS, 32'hffff);
      rd(UDT_CTRL_OFS, 32'h0);
      rd(8'h20, 32'h0);
      chk(perr, 1'b1);
      apb(1'b1, UDT_LIMIT_OFS, 32'h10);
      apb(1'b1, UDT_MASK_OFS, 32'h1f);
      snd(3'h0, 1'b1, 3'h1);
      want(1'b0, 3'h1);
      snd(3'h1, 1'b1, 3'h2);
      want(1'b0, 3'h2);
      snd(3'h2, 1'b1, 3'h2);
      want(1'b1, 3'h3);
      want(1'b0, 3'h4);
      snd(3'h4, 1'b1, 3'h5);
      rd(UDT_STATUS_OFS, 32'h1);
      irqc(1'b1);
      apb(1'b1, UDT_MASK_OFS, 32'h0);
      irqc(1'b0);
      apb(1'b1, UDT_MASK_OFS, 32'h1f);
      apb(1'b1, UDT_STATUS_OFS, 32'h1f);
      irqc(1'b0);
      want(1'b0, 3'h5);
      snd(3'h5, 1'b1, 3'h2);
      want(1'b0, 3'h6);
      snd(3'h6, 1'b0, 3'h3);
      apb(1'b1, UDT_STATUS_OFS, 32'h1f);
      snd(3'h6, 1'b1, 3'h2);
      rd(UDT_STATUS_OFS, 32'h4);
      apb(1'b1, UDT_STATUS_OFS, 32'h1f);
      want(1'b0, 3'h7);
      snd(3'h7, 1'b0, 3'h3);
      want(1'b0, 3'h0);
      snd(3'h0, 1'b1, 3'h2);
      want(1'b0, 3'h5);
      snd(3'h5, 1'b1, 3'h4);
      rd(UDT_STATUS_OFS, 32'h1);
      apb(1'b1, UDT_STATUS_OFS, 32'h1f);
      for (int i = 1; i < 5; i++) want(1'b1, 3'(i));
      want(1'b0, 3'h6);
      snd(3'h6, 1'b1, 3'h2);
      rd(UDT_STATUS_OFS, 32'h2);
      want(1'b0, 3'h2);
      snd(3'h2, 1'b1, 3'h4);
      want(1'b0, 3'h0);
      snd(3'h0, 1'b1, 3'h2);
      want(1'b0, 3'h4);
      snd(3'h4, 1'b1, 3'h4);
      snd(3'h7, 1'b1, 3'h1);
      snd(3'h2, 1'b0, 3'h0);
      snd(3'h0, 1'b1, 3'h1);
      want(1'b0, 3'h1);
      snd(3'h1, 1'b1, 3'h2);
      want(1'b0, 3'h5);
      snd(3'h5, 1'b1, 3'h4);
      snd(3'h3, 1'b0, 3'h0);
      snd(3'h0, 1'b1, 3'h1);
      want(1'b0, 3'h1);
      snd(3'h1, 1'b1, 3'h2);
      repeat (40) @(posedge pclk);
      cmp(3'h2);
      apb(1'b1, UDT_STATUS_OFS, 32'h1f);
      apb(1'b1, UDT_CTRL_OFS, 32'h1);
      want(1'b1, 3'h2);
      repeat (40) @(posedge pclk);
      cmp(3'h6);
      rd(UDT_STATUS_OFS, 32'h10);
    end
    results();
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    results();
  end
endmodule // tb_udt_cell_sequence_tracker

bind udt_cell_sequence_tracker udt_seq_checker u_chk (.*);
